//--- ppfr_regs.svh
// register offsets, field positions, vectors and masks of the fault unit
`ifndef PPFR_REGS_SVH
`define PPFR_REGS_SVH

`define PPFR_ADR_CTRL       8'h00
`define PPFR_ADR_FAULT_ADDR 8'h04
`define PPFR_ADR_ERR_CODE   8'h08
`define PPFR_ADR_STATUS     8'h0c

`define PPFR_CTRL_RST       7'h00
`define PPFR_CTRL_PG_EN     0
`define PPFR_CTRL_WP        1
`define PPFR_CTRL_NX_SUP    2
`define PPFR_CTRL_NX_EN     3
`define PPFR_CTRL_LPE       4
`define PPFR_CTRL_EAE       5
`define PPFR_CTRL_LONG      6
`define PPFR_CTRL_W         7

`define PPFR_VEC_GP         8'h0d
`define PPFR_VEC_PF         8'h0e

`define PPFR_PF_P           0
`define PPFR_PF_W           1
`define PPFR_PF_U           2
`define PPFR_PF_RESERVED_BIT_FLAG        3
`define PPFR_PF_ID          4

`define PPFR_PAGING_ENABLE_BIT_BIT     31
`define PPFR_CR3_RESERVED_BIT_FLAG       64'hfff0_0000_0000_0fe7
`define PPFR_CR4_RESERVED_BIT_FLAG       64'hffff_ffff_ff80_0000
`define PPFR_CR8_RESERVED_BIT_FLAG       64'hffff_ffff_ffff_fff0
`define PPFR_CANON_HI       47

`endif

//--- ppfr_pkg.sv
// types shared by the fault unit and its neighbours
package ppfr_pkg;

	typedef enum logic [2:0] {
		OP_MEM,
		OP_FETCH,
		OP_FAR_XFER,
		OP_GATE64,
		OP_INTERRUPT_RETURN,
		OP_SS_LOAD,
		OP_CTL_WRITE,
		OP_OTHER
	} ppfr_op_t;

	typedef struct packed {
		ppfr_op_t    op;
		logic        mode64;
		logic        compat;
		logic [1:0]  current_privilege_level;
		logic [1:0]  requested_privilege_level;
		logic [1:0]  descriptor_privilege_level;
		logic        nested_task_flag;
		logic        sel_null;
		logic        ret_compat;
		logic [1:0]  ret_cpl;
		logic        is_code;
		logic        l_bit;
		logic        d_bit;
		logic [3:0]  upper_type;
		logic [3:0]  ctl_idx;
		logic [63:0] addr;
		logic [63:0] desc_addr;
		logic        desc_chk;
		logic [63:0] seg_end;
		logic        desc_load;
		logic [15:0] sel;
		logic        ext_gp;
		logic        ts_commit;
		logic        is_write;
		logic        user_mode;
		logic        present_all;
		logic        user_page;
		logic        writable;
		logic        nx_bit;
		logic        reserved_bit_flag_set;
		logic [15:0] cs;
		logic [31:0] ip;
	} ppfr_req_t;

	typedef struct packed {
		logic [7:0]  vector;
		logic [31:0] err_code;
		logic [15:0] cs;
		logic [31:0] ip;
	} ppfr_rpt_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD
	} ppfr_state_t;

endpackage

//--- ppfr_core.sv
// protection and translation fault detection with register slave
//
// Overview of operation
// RULE_01: protection code: selector or vector on descriptor load, else 0
// RULE_02: saved segment and pointer name the faulting instruction
// RULE_03: protection fault before task commit leaves state unchanged
// RULE_04: fault after task commit loads whole new task state, then faults
// RULE_05: 64-bit non-canonical address, target or segment end faults
// RULE_06: 64-bit gate code descriptor needs long bit set and size bit clear.
// RULE_07: interrupt return with nested task flag set faults in 64-bit mode.
// RULE_08: interrupt return null stack selector faults by target mode and privilege.
// RULE_09: code descriptor with both size and long bits set faults.
// RULE_10: call gate privilege below current or requested privilege faults.
// RULE_11: nonzero upper type of a 64-bit call gate faults.
// RULE_12: null stack selector load faults by mode and privilege.
// RULE_13: paging clear in long mode or reserved control bit set faults
// RULE_14: not-present directory or table entry raises a translation fault.
// RULE_15: user access to a supervisor page raises a translation fault.
// RULE_16: read-only page write faults from user, or supervisor with protect; code faults supervisor writes only on user pages
// RULE_17: fetch from execute-disabled page faults when the feature is on.
// RULE_18: set reserved bits in a used directory entry raise a fault
// RULE_19: present flag is 0 for not-present, 1 for protection or reserved.
// RULE_20: error code reports write direction and user privilege
// RULE_21: reserved flag shown only with large-page or extended-address on
// RULE_22: fetch flag only when execute-disable is supported and enabled
// RULE_23: every translation fault loads the faulting linear address.
// RULE_24: later fault overwrites the fault address, even mid-delivery
// RULE_25: error code bits: present 0, write 1, user 2, reserved 3, fetch 4.
// RULE_26: one exception per attempt, and no architectural results
`timescale 1ns/1ns
`include "ppfr_regs.svh"

module ppfr_core
	import ppfr_pkg::*;
(
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic        CHK_VLD_I,
	input  wire ppfr_req_t   CHK_REQ_I,
	output logic             CHK_RDY_O,
	output logic             RETIRE_O,
	output logic             COMMIT_LOAD_O,
	output logic             FAULT_VLD_O,
	output ppfr_rpt_t        FAULT_O,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O
);

	function automatic logic canon_ok(input logic [63:0] a);
		canon_ok = (&a[63:`PPFR_CANON_HI]) | ~(|a[63:`PPFR_CANON_HI]);
	endfunction

	// shared by stack loads and interrupt return
	function automatic logic null_ss_bad(input logic cmp, input logic [1:0] pl,
	                                     input logic [1:0] rq);
		null_ss_bad = cmp | (pl == 2'd3) | (rq != pl);
	endfunction

	ppfr_state_t state_ff;
	logic [`PPFR_CTRL_W-1:0] ctrl_ff;
	logic [31:0] fault_addr_ff;
	logic [31:0] err_last_ff;
	logic [7:0]  vec_last_ff;
	logic [7:0]  gp_cnt_ff;
	logic [7:0]  pf_cnt_ff;
	logic        retire_ff;
	logic        commit_ff;
	logic        fvld_ff;
	ppfr_rpt_t   rpt_ff;
	ppfr_rpt_t   nxt_rpt;
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic        take;
	logic        gp_hit;
	logic        pf_hit;
	logic [31:0] gp_err;
	logic [31:0] pf_err;
	logic        prot_viol;
	logic        pg_en;
	logic        nx_on;
	logic        wb_req;
	ppfr_req_t   r;

	assign r = CHK_REQ_I;
	assign pg_en = ctrl_ff[`PPFR_CTRL_PG_EN];
	assign nx_on = ctrl_ff[`PPFR_CTRL_NX_SUP] & ctrl_ff[`PPFR_CTRL_NX_EN];
	assign CHK_RDY_O = (state_ff == ST_IDLE);
	assign take = CHK_VLD_I & CHK_RDY_O;

	// protection checks, all evaluated in parallel
	always_comb begin
		gp_hit = r.ext_gp;
		if (r.mode64) begin
			// RULE_05: canonical address checks
			if ((r.op == OP_MEM || r.op == OP_FETCH || r.op == OP_FAR_XFER ||
			     r.op == OP_GATE64) && !canon_ok(r.addr))
				gp_hit = 1'b1;
			if (r.desc_chk && !canon_ok(r.desc_addr))
				gp_hit = 1'b1;
			if ((r.op == OP_FAR_XFER || r.op == OP_GATE64) &&
			    !canon_ok(r.seg_end))
				gp_hit = 1'b1;
		end
		// RULE_06: gate target must be a long code segment
		if (r.op == OP_GATE64 && !(r.l_bit && !r.d_bit))
			gp_hit = 1'b1;
		// RULE_10: gate privilege against current and requested
		if (r.op == OP_GATE64 && (r.descriptor_privilege_level < r.current_privilege_level || r.descriptor_privilege_level < r.requested_privilege_level))
			gp_hit = 1'b1;
		// RULE_11: upper type field must be zero
		if (r.op == OP_GATE64 && r.upper_type != 4'h0)
			gp_hit = 1'b1;
		// RULE_09: size and long bits both set
		if ((r.op == OP_INTERRUPT_RETURN || r.op == OP_FAR_XFER) && r.is_code &&
		    r.d_bit && r.l_bit)
			gp_hit = 1'b1;
		// RULE_07: nested task return not allowed
		if (r.op == OP_INTERRUPT_RETURN && r.mode64 && r.nested_task_flag)
			gp_hit = 1'b1;
		// RULE_08: null stack selector on return
		if (r.op == OP_INTERRUPT_RETURN && r.mode64 && r.sel_null &&
		    null_ss_bad(r.ret_compat, r.ret_cpl, r.requested_privilege_level))
			gp_hit = 1'b1;
		// RULE_12: null stack selector load
		if (r.op == OP_SS_LOAD && r.sel_null &&
		    (r.compat || (r.mode64 && null_ss_bad(1'b0, r.current_privilege_level, r.requested_privilege_level))))
			gp_hit = 1'b1;
		// RULE_13: control register writes
		if (r.op == OP_CTL_WRITE) begin
			case (r.ctl_idx)
			4'd0: begin
				if (ctrl_ff[`PPFR_CTRL_LONG] && !r.addr[`PPFR_PAGING_ENABLE_BIT_BIT])
					gp_hit = 1'b1;
			end
			4'd3: begin
				if (|(r.addr & `PPFR_CR3_RESERVED_BIT_FLAG))
					gp_hit = 1'b1;
			end
			4'd4: begin
				if (|(r.addr & `PPFR_CR4_RESERVED_BIT_FLAG))
					gp_hit = 1'b1;
			end
			4'd8: begin
				if (|(r.addr & `PPFR_CR8_RESERVED_BIT_FLAG))
					gp_hit = 1'b1;
			end
			default: begin
			end
			endcase
		end
		// RULE_01: selector only for descriptor loads
		gp_err = r.desc_load ? {16'h0000, r.sel} : 32'h0000_0000;
	end

	// translation checks; only meaningful for memory and fetch
	always_comb begin
		// RULE_15: supervisor page from user code
		// RULE_16: write protect widens to supervisor on user pages
		prot_viol = (r.user_mode && !r.user_page) ||
		            (r.op == OP_MEM && r.is_write && !r.writable &&
		             (r.user_mode ||
		              (ctrl_ff[`PPFR_CTRL_WP] && r.user_page)));
		// RULE_17: execute-disable on fetch
		if (r.op == OP_FETCH && nx_on && r.nx_bit)
			prot_viol = 1'b1;
		// RULE_14: missing entry
		// RULE_18: reserved bits in directory entry
		pf_hit = pg_en && (r.op == OP_MEM || r.op == OP_FETCH) &&
		         (!r.present_all || prot_viol || r.reserved_bit_flag_set);
		pf_err = 32'h0000_0000;
		// RULE_25: fixed bit positions, rest zero
		// RULE_19: present reads 1 only for protection or reserved
		pf_err[`PPFR_PF_P] = r.present_all;
		// RULE_20: direction and privilege
		pf_err[`PPFR_PF_W] = (r.op == OP_MEM) & r.is_write;
		pf_err[`PPFR_PF_U] = r.user_mode;
		// RULE_21: gated by large-page or extended-address enable
		pf_err[`PPFR_PF_RESERVED_BIT_FLAG] = r.reserved_bit_flag_set & (ctrl_ff[`PPFR_CTRL_LPE] |
		                                      ctrl_ff[`PPFR_CTRL_EAE]);
		// RULE_22: fetch flag left zero while feature is off
		pf_err[`PPFR_PF_ID] = nx_on & (r.op == OP_FETCH);
	end

	always_comb begin
		nxt_rpt.cs = r.cs;
		nxt_rpt.ip = r.ip;
		// RULE_26: protection checks precede translation, one wins
		nxt_rpt.vector = gp_hit ? `PPFR_VEC_GP : `PPFR_VEC_PF;
		nxt_rpt.err_code = gp_hit ? gp_err : pf_err;
	end

	// sequencing of report, retirement and task-state load
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_ff <= ST_IDLE;
			retire_ff <= 1'b0;
			commit_ff <= 1'b0;
			fvld_ff <= 1'b0;
		end else begin
			retire_ff <= 1'b0;
			commit_ff <= 1'b0;
			fvld_ff <= 1'b0;
			case (state_ff)
			ST_IDLE: begin
				if (take) begin
					// RULE_04: committed task switch loads state before fault
					if (gp_hit && r.ts_commit) begin
						commit_ff <= 1'b1;
						state_ff <= ST_LOAD;
					end else if (gp_hit || pf_hit) begin
						// RULE_03: no retire, state kept
						fvld_ff <= 1'b1;
					end else begin
						retire_ff <= 1'b1;
					end
				end
			end
			ST_LOAD: begin
				fvld_ff <= 1'b1;
				state_ff <= ST_IDLE;
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end

	// report contents held until the next fault
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rpt_ff <= '0;
		end else if (take && (gp_hit || pf_hit)) begin
			// RULE_02: faulting instruction, not the next one
			rpt_ff <= nxt_rpt;
		end
	end

	// last fault summary for software
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			err_last_ff <= 32'h0000_0000;
			vec_last_ff <= 8'h00;
			gp_cnt_ff <= 8'h00;
			pf_cnt_ff <= 8'h00;
		end else if (take && (gp_hit || pf_hit)) begin
			err_last_ff <= nxt_rpt.err_code;
			vec_last_ff <= nxt_rpt.vector;
			if (gp_hit)
				gp_cnt_ff <= gp_cnt_ff + 8'h01;
			else
				pf_cnt_ff <= pf_cnt_ff + 8'h01;
		end
	end

	// fault address; hardware update beats a software write
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			fault_addr_ff <= 32'h0000_0000;
		end else if (take && pf_hit && !gp_hit) begin
			// RULE_23: faulting linear address
			// RULE_24: no guard on delivery in flight, newest wins
			fault_addr_ff <= r.addr[31:0];
		end else if (wb_req && !ack_ff && WB_WE_I &&
		             WB_ADR_I == `PPFR_ADR_FAULT_ADDR) begin
			for (int i = 0; i < 4; i++) begin
				if (WB_SEL_I[i])
					fault_addr_ff[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
			end
		end
	end

	assign RETIRE_O = retire_ff;
	assign COMMIT_LOAD_O = commit_ff;
	assign FAULT_VLD_O = fvld_ff;
	assign FAULT_O = rpt_ff;

	// wishbone slave, one wait state, unmapped reads zero
	assign wb_req = WB_CYC_I & WB_STB_I;

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_req & ~ack_ff;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_ff <= `PPFR_CTRL_RST;
		end else if (wb_req && !ack_ff && WB_WE_I && WB_SEL_I[0] &&
		             WB_ADR_I == `PPFR_ADR_CTRL) begin
			ctrl_ff <= WB_DAT_I[`PPFR_CTRL_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rdat_ff <= 32'h0000_0000;
		end else if (wb_req && !ack_ff) begin
			case (WB_ADR_I)
			`PPFR_ADR_CTRL:
				rdat_ff <= {{(32-`PPFR_CTRL_W){1'b0}}, ctrl_ff};
			`PPFR_ADR_FAULT_ADDR:
				rdat_ff <= fault_addr_ff;
			`PPFR_ADR_ERR_CODE:
				rdat_ff <= err_last_ff;
			`PPFR_ADR_STATUS:
				rdat_ff <= {7'h00, CHK_RDY_O, pf_cnt_ff, gp_cnt_ff,
				            vec_last_ff};
			default:
				rdat_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = rdat_ff;

	// checks on the fault path
	logic        ck_gp;
	logic        ck_pf;
	logic        ck_commit;
	assign ck_gp = take & gp_hit;
	assign ck_pf = take & pf_hit & ~gp_hit;
	assign ck_commit = take & gp_hit & r.ts_commit;

	gp_errcode_a: assert property ( // RULE_01
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		ck_gp && !r.ts_commit && !r.desc_load |=>
			FAULT_VLD_O && FAULT_O.err_code == 32'h0000_0000)
		else $error("protection error code not zero");

	saved_ip_a: assert property ( // RULE_02
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		(ck_gp || ck_pf) && !r.ts_commit |=>
			FAULT_O.ip == $past(r.ip) && FAULT_O.cs == $past(r.cs))
		else $error("saved pointer differs from faulting one");

	no_retire_a: assert property ( // RULE_03
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		ck_gp && !r.ts_commit |=> !RETIRE_O && !COMMIT_LOAD_O)
		else $error("state changed on early protection fault");

	commit_order_a: assert property ( // RULE_04
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		ck_commit |=> COMMIT_LOAD_O && !FAULT_VLD_O ##1
			FAULT_VLD_O && FAULT_O.vector == `PPFR_VEC_GP)
		else $error("task state not loaded before fault");

	canon_gp_a: assert property ( // RULE_05
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		take && r.mode64 && r.op == OP_MEM && !r.ts_commit &&
		!canon_ok(r.addr) |=>
			FAULT_VLD_O && FAULT_O.vector == `PPFR_VEC_GP)
		else $error("non-canonical address not faulted");

	nt_interrupt_return_a: assert property ( // RULE_07
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		take && r.op == OP_INTERRUPT_RETURN && r.mode64 && r.nested_task_flag |=>
			!RETIRE_O)
		else $error("nested return retired");

	ss_null_a: assert property ( // RULE_12
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		take && r.op == OP_SS_LOAD && r.sel_null && r.compat |=>
			!RETIRE_O)
		else $error("null stack load retired");

	pf_addr_a: assert property ( // RULE_23
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		ck_pf |=> fault_addr_ff == $past(r.addr[31:0]) && FAULT_VLD_O &&
			FAULT_O.vector == `PPFR_VEC_PF)
		else $error("fault address not captured");

	pf_present_a: assert property ( // RULE_19
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		ck_pf |=> FAULT_O.err_code[`PPFR_PF_P] == $past(r.present_all) &&
			FAULT_O.err_code[31:5] == 27'h0)
		else $error("translation error code wrong");

	single_exc_a: assert property ( // RULE_26
		@(posedge REF_CLK_I) disable iff (!RST_B_I)
		FAULT_VLD_O |-> !RETIRE_O && !COMMIT_LOAD_O)
		else $error("fault and retire together");

endmodule

//--- ppfr_issuer.sv
// far-side model: streams instruction attempts and logs outcomes
`timescale 1ns/1ns

module ppfr_issuer
	import ppfr_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_b_i,
	input  wire logic      rdy_i,
	input  wire logic      retire_i,
	input  wire logic      commit_i,
	input  wire logic      fault_i,
	input  wire ppfr_rpt_t rpt_i,
	output logic           vld_o,
	output ppfr_req_t      req_o
);
	ppfr_req_t  pend_q[$];
	logic [1:0] kind_q[$];
	ppfr_rpt_t  rpt_q[$];

	initial begin
		vld_o = 1'b0;
		req_o = '0;
	end

	// request held until the edge that takes it
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vld_o <= 1'b0;
		end else begin
			if (vld_o && rdy_i)
				void'(pend_q.pop_front());
			if (pend_q.size() != 0) begin
				vld_o <= 1'b1;
				req_o <= pend_q[0];
			end else begin
				vld_o <= 1'b0;
				// released lines must not keep the old value
				req_o <= ~req_o;
			end
			if (retire_i)
				kind_q.push_back(2'h0);
			if (fault_i) begin
				kind_q.push_back(2'h1);
				rpt_q.push_back(rpt_i);
			end
			if (commit_i)
				kind_q.push_back(2'h2);
		end
	end
endmodule

//--- ppfr_core_tb.sv
// self-checking bench for the fault unit
`timescale 1ns/1ns
`include "ppfr_regs.svh"

module ppfr_core_tb
	import ppfr_pkg::*;
;
	localparam logic [7:0] VPROT = `PPFR_VEC_GP;
	localparam logic [7:0] VXLAT = `PPFR_VEC_PF;

	logic        clk;
	logic        rst_b;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        vld;
	logic        rdy;
	logic        retire;
	logic        commit;
	logic        fault;
	ppfr_req_t   req;
	ppfr_rpt_t   rpt;
	ppfr_req_t   r;
	logic [31:0] q;
	logic [7:0]  lastv;
	int          ngp;
	int          npf;
	int          n_mismatch;
	int          check_count;

	ppfr_core ppfr_core_inst (
		.REF_CLK_I     (clk),
		.RST_B_I       (rst_b),
		.CHK_VLD_I     (vld),
		.CHK_REQ_I     (req),
		.CHK_RDY_O     (rdy),
		.RETIRE_O      (retire),
		.COMMIT_LOAD_O (commit),
		.FAULT_VLD_O   (fault),
		.FAULT_O       (rpt),
		.WB_CYC_I      (cyc),
		.WB_STB_I      (stb),
		.WB_WE_I       (we),
		.WB_ADR_I      (adr),
		.WB_SEL_I      (sel),
		.WB_DAT_I      (wdat),
		.WB_DAT_O      (rdat),
		.WB_ACK_O      (ack)
	);

	ppfr_issuer ppfr_issuer_inst (
		.clk_i    (clk),
		.rst_b_i  (rst_b),
		.rdy_i    (rdy),
		.retire_i (retire),
		.commit_i (commit),
		.fault_i  (fault),
		.rpt_i    (rpt),
		.vld_o    (vld),
		.req_o    (req)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// classic cycle: request held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		wdat <= ~d;
		if (n >= 50)
			check("ack", 0, 1);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hf);
		check(nm, q, e);
	endtask

	task automatic ctrl(input logic [31:0] d);
		wb(1'b1, `PPFR_ADR_CTRL, d, 4'hf);
	endtask

	function automatic ppfr_req_t mk(input ppfr_op_t op);
		ppfr_req_t x;
		x = '0;
		x.op = op;
		x.mode64 = 1'b1;
		x.l_bit = 1'b1;
		x.present_all = 1'b1;
		x.user_page = 1'b1;
		x.writable = 1'b1;
		x.cs = 16'h0010;
		x.ip = 32'h0040_1000 + 32'(op);
		return x;
	endfunction

	task automatic push(input ppfr_req_t x);
		@(negedge clk);
		ppfr_issuer_inst.pend_q.push_back(x);
	endtask

	// v of zero means the attempt should retire
	task automatic expect_out(input ppfr_req_t x, input logic [7:0] v,
		input logic [31:0] e);
		int n;
		int cnt;
		ppfr_rpt_t p;
		cnt = (x.ts_commit && v != 8'h0) ? 2 : 1;
		n = 0;
		while (ppfr_issuer_inst.kind_q.size() < cnt && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			check("outcome", 0, 1);
			return;
		end
		if (cnt == 2)
			check("commit", ppfr_issuer_inst.kind_q.pop_front(), 2);
		check("kind", ppfr_issuer_inst.kind_q.pop_front(), v != 8'h0);
		if (v != 8'h0) begin
			p = ppfr_issuer_inst.rpt_q.pop_front();
			check("vector", p.vector, v);
			check("code", p.err_code, e);
			check("cs", p.cs, x.cs);
			check("ip", p.ip, x.ip);
			lastv = v;
			if (v == VPROT)
				ngp++;
			else
				npf++;
		end
	endtask

	task automatic run(input ppfr_req_t x, input logic [7:0] v,
		input logic [31:0] e);
		push(x);
		expect_out(x, v, e);
	endtask

	initial begin
		ppfr_req_t b;
		n_mismatch = 0;
		check_count = 0;
		ngp = 0;
		npf = 0;
		lastv = 8'h0;
		rst_b = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		sel = 4'h0;
		wdat = 32'h0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rdchk("ctrl", `PPFR_ADR_CTRL, 32'h0);
		wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		rdchk("unmapped", 8'h40, 32'h0);
		r = mk(OP_MEM);
		run(r, 8'h0, 32'h0);
		r.addr = 64'h0000_8000_0000_0000;
		run(r, VPROT, 32'h0);
		r = mk(OP_FAR_XFER);
		r.seg_end = 64'h0001_0000_0000_0000;
		run(r, VPROT, 32'h0);
		r = mk(OP_MEM);
		r.desc_chk = 1'b1;
		r.desc_addr = 64'hffff_0000_0000_0000;
		run(r, VPROT, 32'h0);
		r = mk(OP_FAR_XFER);
		r.desc_load = 1'b1;
		r.sel = 16'h1235;
		r.is_code = 1'b1;
		r.d_bit = 1'b1;
		run(r, VPROT, 32'h0000_1235);
		r = mk(OP_GATE64);
		r.l_bit = 1'b0;
		run(r, VPROT, 32'h0);
		r = mk(OP_GATE64);
		r.current_privilege_level = 2'h2;
		r.requested_privilege_level = 2'h2;
		r.descriptor_privilege_level = 2'h2;
		run(r, 8'h0, 32'h0);
		r.descriptor_privilege_level = 2'h1;
		run(r, VPROT, 32'h0);
		r.current_privilege_level = 2'h0;
		r.requested_privilege_level = 2'h3;
		r.descriptor_privilege_level = 2'h2;
		run(r, VPROT, 32'h0);
		r = mk(OP_GATE64);
		r.upper_type = 4'h8;
		run(r, VPROT, 32'h0);
		r = mk(OP_INTERRUPT_RETURN);
		r.nested_task_flag = 1'b1;
		run(r, VPROT, 32'h0);
		r.ts_commit = 1'b1;
		b = mk(OP_OTHER);
		push(r);
		push(b);
		expect_out(r, VPROT, 32'h0);
		expect_out(b, 8'h0, 32'h0);
		r = mk(OP_INTERRUPT_RETURN);
		r.sel_null = 1'b1;
		r.ret_compat = 1'b1;
		run(r, VPROT, 32'h0);
		r.ret_compat = 1'b0;
		r.ret_cpl = 2'h3;
		run(r, VPROT, 32'h0);
		r.ret_cpl = 2'h2;
		r.requested_privilege_level = 2'h1;
		run(r, VPROT, 32'h0);
		r = mk(OP_SS_LOAD);
		r.sel_null = 1'b1;
		r.mode64 = 1'b0;
		r.compat = 1'b1;
		run(r, VPROT, 32'h0);
		r.mode64 = 1'b1;
		r.compat = 1'b0;
		r.current_privilege_level = 2'h3;
		r.requested_privilege_level = 2'h3;
		run(r, VPROT, 32'h0);
		r.current_privilege_level = 2'h1;
		r.requested_privilege_level = 2'h2;
		run(r, VPROT, 32'h0);
		r.requested_privilege_level = 2'h1;
		run(r, 8'h0, 32'h0);
		ctrl(32'h41);
		r = mk(OP_CTL_WRITE);
		run(r, VPROT, 32'h0);
		r.addr = 64'h8000_0000;
		run(r, 8'h0, 32'h0);
		r.ctl_idx = 4'h4;
		r.addr = 64'h0080_0000;
		run(r, VPROT, 32'h0);
		r.ctl_idx = 4'h8;
		r.addr = 64'h10;
		run(r, VPROT, 32'h0);
		r.ctl_idx = 4'h3;
		r.addr = 64'h1;
		run(r, VPROT, 32'h0);
		r = mk(OP_MEM);
		r.present_all = 1'b0;
		r.is_write = 1'b1;
		r.user_mode = 1'b1;
		r.addr = 64'h1234_5000;
		run(r, VXLAT, 32'h6);
		rdchk("faddr", `PPFR_ADR_FAULT_ADDR, 32'h1234_5000);
		r = mk(OP_MEM);
		r.user_mode = 1'b1;
		r.user_page = 1'b0;
		run(r, VXLAT, 32'h5);
		r.user_page = 1'b1;
		r.writable = 1'b0;
		r.is_write = 1'b1;
		run(r, VXLAT, 32'h7);
		r.user_mode = 1'b0;
		run(r, 8'h0, 32'h0);
		ctrl(32'h43);
		run(r, VXLAT, 32'h3);
		r = mk(OP_FETCH);
		r.nx_bit = 1'b1;
		run(r, 8'h0, 32'h0);
		r.present_all = 1'b0;
		run(r, VXLAT, 32'h0);
		r.present_all = 1'b1;
		ctrl(32'h4f);
		run(r, VXLAT, 32'h11);
		r = mk(OP_MEM);
		r.reserved_bit_flag_set = 1'b1;
		r.addr = 64'h7000;
		run(r, VXLAT, 32'h1);
		ctrl(32'h5f);
		b = mk(OP_MEM);
		b.present_all = 1'b0;
		b.is_write = 1'b1;
		b.user_mode = 1'b1;
		b.addr = 64'h8000;
		push(r);
		push(b);
		expect_out(r, VXLAT, 32'h9);
		expect_out(b, VXLAT, 32'h6);
		rdchk("faddr", `PPFR_ADR_FAULT_ADDR, 32'h8000);
		wb(1'b1, `PPFR_ADR_ERR_CODE, 32'hff, 4'hf);
		rdchk("errcode", `PPFR_ADR_ERR_CODE, 32'h6);
		wb(1'b1, `PPFR_ADR_FAULT_ADDR, 32'hdead_beef, 4'h3);
		rdchk("faddr", `PPFR_ADR_FAULT_ADDR, 32'hbeef);
		r = mk(OP_MEM);
		r.addr = 64'h0000_8000_0000_0000;
		r.present_all = 1'b0;
		run(r, VPROT, 32'h0);
		rdchk("faddr", `PPFR_ADR_FAULT_ADDR, 32'hbeef);
		rdchk("status", `PPFR_ADR_STATUS,
			{7'h0, 1'b1, 8'(npf), 8'(ngp), lastv});
		// mid-run reset clears registers and counters
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		check("reset", {retire, commit, fault, rdy, ack}, 5'h02);
		rst_b <= 1'b1;
		rdchk("ctrl", `PPFR_ADR_CTRL, 32'h0);
		rdchk("faddr", `PPFR_ADR_FAULT_ADDR, 32'h0);
		rdchk("status", `PPFR_ADR_STATUS, 32'h0100_0000);
		give_verdict();
	end

	// whole run needs well under 2000 cycles
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
